/* arc_lock.sv */
// Write protection check and violation record.
// Assumes wr_go marks the one edge at which an APB write takes effect.
`timescale 1ns/1ps
module arc_lock (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clr,
	// Write attempt
	input  wire logic        wr_go,
	input  wire logic [7:0]  waddr,
	input  wire logic        lock_enable,
	input  wire logic        key_clear,
	// Result
	output logic             blocked,
	output logic             lock_violation_flag,
	output logic [7:0]       viol_src
);

	logic guarded;

	always_comb
	begin
		case (waddr)
			arc_pkg::OFF_CFG, arc_pkg::OFF_ORD_LO, arc_pkg::OFF_ORD_HI,
			arc_pkg::OFF_ACT, arc_pkg::OFF_DEACT, arc_pkg::OFF_EXTRA,
			arc_pkg::OFF_WINDOW: guarded = 1'b1;
			default:             guarded = 1'b0;
		endcase
	end

	assign blocked = wr_go && lock_enable && guarded;

	// A new violation wins over a clearing key write.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn) begin
			lock_violation_flag <= 1'b0;
			viol_src            <= 8'h00;
		end else if (clr) begin
			lock_violation_flag <= 1'b0;
			viol_src            <= 8'h00;
		end else if (blocked) begin
			lock_violation_flag <= 1'b1;
			viol_src            <= waddr;
		end else if (key_clear) begin
			lock_violation_flag <= 1'b0;
			viol_src            <= 8'h00;
		end
	end

endmodule : arc_lock

/* arc_pkg.sv */
// Shared constants of the converter register block.
// Assumes an APB slave with an 8-bit byte address and 32-bit data.
package arc_pkg;

	// ********************************************************************
	// Sizes
	// ********************************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int N_CH   = 16;
	localparam int CH_W   = 4;
	localparam int RES_W  = 12;

	// ********************************************************************
	// Register offsets
	// ********************************************************************
	localparam logic [7:0] OFF_CMD       = 8'h00;
	localparam logic [7:0] OFF_CFG       = 8'h04;
	localparam logic [7:0] OFF_ORD_LO    = 8'h08;
	localparam logic [7:0] OFF_ORD_HI    = 8'h0C;
	localparam logic [7:0] OFF_ACT       = 8'h10;
	localparam logic [7:0] OFF_DEACT     = 8'h14;
	localparam logic [7:0] OFF_ACT_ST    = 8'h18;
	localparam logic [7:0] OFF_LATEST    = 8'h20;
	localparam logic [7:0] OFF_ARM       = 8'h24;
	localparam logic [7:0] OFF_DISARM    = 8'h28;
	localparam logic [7:0] OFF_ARMED     = 8'h2C;
	localparam logic [7:0] OFF_EVENTS    = 8'h30;
	localparam logic [7:0] OFF_OVER      = 8'h3C;
	localparam logic [7:0] OFF_EXTRA     = 8'h40;
	localparam logic [7:0] OFF_WINDOW    = 8'h44;
	localparam logic [7:0] OFF_RES_FIRST = 8'h50;
	localparam logic [7:0] OFF_RES_LAST  = 8'h8C;
	localparam logic [7:0] OFF_LOCK_CFG  = 8'hE4;
	localparam logic [7:0] OFF_LOCK_ST   = 8'hE8;

	// ********************************************************************
	// Fields and reset values
	// ********************************************************************
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;
	localparam int          CMD_RST_BIT   = 0;
	localparam int          CMD_START_BIT = 1;
	localparam int          CFG_ORDER_BIT = 31;
	localparam int          EV_DRDY       = 24;
	localparam int          EV_GOVRE      = 25;
	localparam int          EV_COMPE      = 26;
	localparam int          EXT_MODE_LSB  = 0;
	localparam int          EXT_SEL_LSB   = 4;
	localparam int          EXT_ALL_BIT   = 9;
	localparam int          WIN_LOW_LSB   = 0;
	localparam int          WIN_HIGH_LSB  = 16;
	localparam int          LATEST_CH_LSB = 12;
	localparam int          LOCK_EN_BIT   = 0;
	localparam int          LOCK_KEY_LSB  = 8;
	localparam int          LOCK_SRC_LSB  = 8;
	// Arbitrary unlock key value.
	localparam logic [23:0] LOCK_KEY      = 24'h5A5A5A;

	typedef enum logic [1:0] {CMP_LOW, CMP_HIGH, CMP_IN, CMP_OUT} arc_cmp_e;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_SCAN, SEQ_WAIT} arc_seq_e;

endpackage : arc_pkg

/* arc_regs.sv */
// Register bank of the multi-channel converter controller, APB slave.
// Assumes an APB master on pclk and an analog cell on the same clock.
//
// What this block does
// - Unlisted offsets are reserved: zero, slave error.
// - Command bit 0 resets the whole block.
// - Command bit 1 starts conversion; write-only.
// - Sixteen result registers, 0x50 to 0x8C.
// - Latest result readable at 0x20, resets zero.
// - Violation status 0xE8, lock mode 0xE4.
// - One start converts all enabled slots, then idles.
// - Lock blocks guarded writes, records violation source.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module arc_regs (
	// Clock and reset
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	// APB
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [arc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic                            pready,
	output logic [31:0]                     prdata,
	output logic                            pslverr,
	// Interrupt
	output logic                            irq,
	// Analog cell
	output logic                            conv_req,
	output logic [arc_pkg::CH_W-1:0]        conv_chan,
	input  wire logic                       conv_done,
	input  wire logic [arc_pkg::RES_W-1:0]  conv_data
);

	localparam int RW = arc_pkg::RES_W;

	logic [31:0]            operating_config;
	logic [31:0]            order_list_low;
	logic [31:0]            order_list_high;
	logic [31:0]            extra_config;
	logic [31:0]            threshold_window;
	logic [15:0]            input_active_state;
	logic [31:0]            irq_armed_state;
	logic [31:0]            event_flags;
	logic [15:0]            overwrite_flags;
	logic [31:0]            latest_result;
	logic [RW-1:0]          chan_result [arc_pkg::N_CH];
	logic                   lock_enable;
	logic                   lock_violation_flag;
	logic [7:0]             viol_src;
	logic [31:0]            lock_violation_state;

	logic                   setup;
	logic                   access;
	logic                   wr_go;
	logic                   rd_go;
	logic                   mapped;
	logic                   blocked;
	logic                   block_soft_reset;
	logic                   start_cmd;
	logic                   key_clear;
	logic [7:0]             res_off;
	logic [3:0]             res_idx;
	logic [31:0]            next_rdata;
	logic                   busy;
	logic                   res_valid;
	logic [3:0]             res_chan;
	logic [RW-1:0]          res_data;
	logic                   cmp_hit;
	logic [31:0]            ev_set;
	logic [31:0]            ev_clr;
	logic [15:0]            ov_set;
	logic [15:0]            ov_clr;

	// ********************************************************************
	// APB decode
	// ********************************************************************
	assign setup   = psel && !penable;
	assign access  = psel && penable;
	assign wr_go   = access && pwrite;
	assign rd_go   = access && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;
	assign res_off = paddr - arc_pkg::OFF_RES_FIRST;
	assign res_idx = res_off[5:2];

	always_comb
	begin
		case (paddr)
			arc_pkg::OFF_CMD, arc_pkg::OFF_CFG, arc_pkg::OFF_ORD_LO,
			arc_pkg::OFF_ORD_HI, arc_pkg::OFF_ACT, arc_pkg::OFF_DEACT,
			arc_pkg::OFF_ACT_ST, arc_pkg::OFF_LATEST, arc_pkg::OFF_ARM,
			arc_pkg::OFF_DISARM, arc_pkg::OFF_ARMED, arc_pkg::OFF_EVENTS,
			arc_pkg::OFF_OVER, arc_pkg::OFF_EXTRA, arc_pkg::OFF_WINDOW,
			arc_pkg::OFF_LOCK_CFG, arc_pkg::OFF_LOCK_ST:
				mapped = 1'b1;
			default:
				mapped = paddr[1:0] == 2'h0
					&& paddr >= arc_pkg::OFF_RES_FIRST
					&& paddr <= arc_pkg::OFF_RES_LAST;
		endcase
	end

	// Reset wins over start when both command bits are written.
	assign block_soft_reset = wr_go && paddr == arc_pkg::OFF_CMD
		&& pwdata[arc_pkg::CMD_RST_BIT];
	assign start_cmd = wr_go && paddr == arc_pkg::OFF_CMD
		&& pwdata[arc_pkg::CMD_START_BIT] && !block_soft_reset;
	assign key_clear = wr_go && paddr == arc_pkg::OFF_LOCK_CFG
		&& pwdata[arc_pkg::LOCK_KEY_LSB +: 24] == arc_pkg::LOCK_KEY;

	// ********************************************************************
	// Configuration registers
	// ********************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn || block_soft_reset) begin
			operating_config <= arc_pkg::RST_WORD;
			order_list_low   <= arc_pkg::RST_WORD;
			order_list_high  <= arc_pkg::RST_WORD;
			extra_config     <= arc_pkg::RST_WORD;
			threshold_window <= arc_pkg::RST_WORD;
		end else if (wr_go && !blocked) begin
			case (paddr)
				arc_pkg::OFF_CFG:    operating_config <= pwdata;
				arc_pkg::OFF_ORD_LO: order_list_low   <= pwdata;
				arc_pkg::OFF_ORD_HI: order_list_high  <= pwdata;
				arc_pkg::OFF_EXTRA:  extra_config     <= pwdata;
				arc_pkg::OFF_WINDOW: threshold_window <= pwdata;
				default:             ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn || block_soft_reset)
			lock_enable <= 1'b0;
		else if (key_clear)
			lock_enable <= pwdata[arc_pkg::LOCK_EN_BIT];
	end

	// Set and clear registers touch only the bits written as one.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn || block_soft_reset)
			input_active_state <= 16'h0000;
		else if (wr_go && !blocked && paddr == arc_pkg::OFF_ACT)
			input_active_state <= input_active_state
				| pwdata[15:0];
		else if (wr_go && !blocked && paddr == arc_pkg::OFF_DEACT)
			input_active_state <= input_active_state
				& ~pwdata[15:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn || block_soft_reset)
			irq_armed_state <= arc_pkg::RST_WORD;
		else if (wr_go && paddr == arc_pkg::OFF_ARM)
			irq_armed_state <= irq_armed_state | pwdata;
		else if (wr_go && paddr == arc_pkg::OFF_DISARM)
			irq_armed_state <= irq_armed_state & ~pwdata;
	end

	// ********************************************************************
	// Sequencer and write protection
	// ********************************************************************
	arc_seq u_seq (
		.pclk      (pclk),
		.presetn   (presetn),
		.clr       (block_soft_reset),
		.start     (start_cmd),
		.active    (input_active_state),
		.use_order (operating_config[arc_pkg::CFG_ORDER_BIT]),
		.order     ({order_list_high, order_list_low}),
		.busy      (busy),
		.conv_req  (conv_req),
		.conv_chan (conv_chan),
		.conv_done (conv_done),
		.conv_data (conv_data),
		.res_valid (res_valid),
		.res_chan  (res_chan),
		.res_data  (res_data)
	);

	arc_lock u_lock (
		.pclk                (pclk),
		.presetn             (presetn),
		.clr                 (block_soft_reset),
		.wr_go               (wr_go),
		.waddr               (paddr),
		.lock_enable         (lock_enable),
		.key_clear           (key_clear),
		.blocked             (blocked),
		.lock_violation_flag (lock_violation_flag),
		.viol_src            (viol_src)
	);

	assign lock_violation_state = {16'h0000, viol_src,
		7'h00, lock_violation_flag};

	// ********************************************************************
	// Results and compare window
	// ********************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn || block_soft_reset) begin
			latest_result <= arc_pkg::RST_WORD;
			for (int i = 0; i < arc_pkg::N_CH; i++)
				chan_result[i] <= '0;
		end else if (res_valid) begin
			chan_result[res_chan] <= res_data;
			latest_result <= {16'h0000, res_chan, res_data};
		end
	end

	always_comb
	begin
		logic [RW-1:0] lo;
		logic [RW-1:0] hi;
		logic          in_win;
		logic          sel_ok;
		lo     = threshold_window[arc_pkg::WIN_LOW_LSB +: RW];
		hi     = threshold_window[arc_pkg::WIN_HIGH_LSB +: RW];
		in_win = res_data >= lo && res_data <= hi;
		sel_ok = extra_config[arc_pkg::EXT_ALL_BIT]
			|| extra_config[arc_pkg::EXT_SEL_LSB +: 4] == res_chan;
		case (arc_pkg::arc_cmp_e'(extra_config[arc_pkg::EXT_MODE_LSB +: 2]))
			arc_pkg::CMP_LOW:  cmp_hit = res_data < lo;
			arc_pkg::CMP_HIGH: cmp_hit = res_data > hi;
			arc_pkg::CMP_IN:   cmp_hit = in_win;
			default:           cmp_hit = !in_win;
		endcase
		cmp_hit = cmp_hit && sel_ok;
	end

	// ********************************************************************
	// Events and interrupt
	// ********************************************************************
	// Only bits already returned to software are cleared by the read, so an
	// event landing between setup and access phases is never lost.
	always_comb
	begin
		ev_set = 32'h0000_0000;
		ov_set = 16'h0000;
		if (res_valid) begin
			ev_set[res_chan]          = 1'b1;
			ev_set[arc_pkg::EV_DRDY]  = 1'b1;
			ev_set[arc_pkg::EV_GOVRE] = event_flags[arc_pkg::EV_DRDY];
			ev_set[arc_pkg::EV_COMPE] = cmp_hit;
			ov_set[res_chan]          = event_flags[res_chan];
		end
	end

	assign ev_clr = rd_go && paddr == arc_pkg::OFF_EVENTS ? prdata : '0;
	assign ov_clr = rd_go && paddr == arc_pkg::OFF_OVER ? prdata[15:0] : '0;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn || block_soft_reset) begin
			event_flags     <= arc_pkg::RST_WORD;
			overwrite_flags <= 16'h0000;
		end else begin
			event_flags     <= (event_flags & ~ev_clr) | ev_set;
			overwrite_flags <= (overwrite_flags & ~ov_clr) | ov_set;
		end
	end

	assign irq = |(event_flags & irq_armed_state);

	// ********************************************************************
	// Read path
	// ********************************************************************
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (paddr)
			arc_pkg::OFF_CFG:      next_rdata = operating_config;
			arc_pkg::OFF_ORD_LO:   next_rdata = order_list_low;
			arc_pkg::OFF_ORD_HI:   next_rdata = order_list_high;
			arc_pkg::OFF_ACT_ST:   next_rdata = {16'h0000, input_active_state};
			arc_pkg::OFF_LATEST:   next_rdata = latest_result;
			arc_pkg::OFF_ARMED:    next_rdata = irq_armed_state;
			arc_pkg::OFF_EVENTS:   next_rdata = event_flags;
			arc_pkg::OFF_OVER:     next_rdata = {16'h0000, overwrite_flags};
			arc_pkg::OFF_EXTRA:    next_rdata = extra_config;
			arc_pkg::OFF_WINDOW:   next_rdata = threshold_window;
			arc_pkg::OFF_LOCK_CFG: next_rdata = {31'h0, lock_enable};
			arc_pkg::OFF_LOCK_ST:  next_rdata = lock_violation_state;
			default:
				if (mapped && paddr != arc_pkg::OFF_CMD && paddr
					!= arc_pkg::OFF_ACT && paddr != arc_pkg::OFF_DEACT
					&& paddr != arc_pkg::OFF_ARM
					&& paddr != arc_pkg::OFF_DISARM)
					next_rdata = {20'h0_0000, chan_result[res_idx]};
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup)
			prdata <= next_rdata;
	end

	// ********************************************************************
	// Assertions
	// ********************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_reserved;
		access && !mapped |-> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("Reserved offset not answered with zero and error.");

	property p_soft_reset;
		block_soft_reset |=> operating_config == 32'h0
			&& input_active_state == 16'h0 && !busy && !irq;
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("Soft reset left state behind.");

	property p_start;
		start_cmd && !busy |=> busy;
	endproperty
	a_start: assert property (p_start)
		else $error("Start command did not start the sequencer.");

	property p_cmd_read;
		rd_go && paddr == arc_pkg::OFF_CMD |-> prdata == 32'h0;
	endproperty
	a_cmd_read: assert property (p_cmd_read)
		else $error("Command register read back non-zero.");

	property p_chan_store;
		res_valid && !block_soft_reset |=>
			chan_result[$past(res_chan)] == $past(res_data);
	endproperty
	a_chan_store: assert property (p_chan_store)
		else $error("Channel result not stored.");

	property p_latest;
		res_valid && !block_soft_reset |=> latest_result[11:0]
			== $past(res_data) && latest_result[15:12] == $past(res_chan);
	endproperty
	a_latest: assert property (p_latest)
		else $error("Latest result not updated.");

	property p_violation;
		blocked |=> lock_violation_state[0]
			&& lock_violation_state[15:8] == $past(paddr);
	endproperty
	a_violation: assert property (p_violation)
		else $error("Violation not recorded.");

	property p_activate;
		wr_go && paddr == arc_pkg::OFF_ACT && !blocked |=>
			input_active_state == ($past(input_active_state)
			| $past(pwdata[15:0]));
	endproperty
	a_activate: assert property (p_activate)
		else $error("Channel enable did not merge bits.");

	property p_blocked_keeps;
		blocked && paddr == arc_pkg::OFF_CFG |=>
			$stable(operating_config);
	endproperty
	a_blocked_keeps: assert property (p_blocked_keeps)
		else $error("Protected register changed under lock.");

	c_irq: cover property (res_valid ##1 irq);
	c_violation: cover property (blocked);
	c_read_clear: cover property (rd_go && paddr == arc_pkg::OFF_EVENTS
		&& prdata != 32'h0);

endmodule : arc_regs

/* arc_regs_tb.sv */
// Self-checking bench for the converter register block.
// Assumes arc_regs alone on one 100 MHz clock; the bench plays bus and cell.
`timescale 1ns/1ps
module arc_regs_tb_top;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        irq, conv_req, conv_done;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  conv_chan;
	logic [11:0] conv_data;
	logic        er;
	int          err_total, comparisons;

	arc_regs arc_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
		.conv_req(conv_req), .conv_chan(conv_chan),
		.conv_done(conv_done), .conv_data(conv_data));

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task wrap_up;
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task chk_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit

	// Waits for pready rather than assuming zero wait states.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			err_total++;
			wrap_up();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rchk

	// Answers one conversion request after checking its channel.
	task serve(input logic [3:0] ch, input logic [11:0] d);
		int n;
		n = 0;
		do begin @(posedge pclk); n++; end while (conv_req !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			err_total++;
			wrap_up();
		end
		chk({28'h0, conv_chan}, {28'h0, ch});
		conv_done <= 1'b1;
		conv_data <= d;
		@(posedge pclk);
		conv_done <= 1'b0;
	endtask : serve

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task t_reset;
		logic [7:0] offs [7] = '{8'h18, 8'h20, 8'h50, 8'h8C, 8'h2C, 8'h30, 8'hE8};
		foreach (offs[i]) rchk(offs[i], 32'h0);
		apb(1'b1, 8'h20, 32'hFFFF_FFFF);
		rchk(8'h20, 32'h0);
		apb(1'b0, 8'h1C, 32'h0);
		chk_bit(er, 1'b1);
		apb(1'b1, 8'h90, 32'h0);
		chk_bit(er, 1'b1);
		apb(1'b0, 8'h00, 32'h0);
		chk_bit(er, 1'b0);
		$display("test reset done");
	endtask : t_reset

	task t_conv;
		int n;
		apb(1'b1, 8'h10, 32'h0000_0025);
		apb(1'b1, 8'h14, 32'h0000_0001);
		rchk(8'h18, 32'h0000_0024);
		apb(1'b1, 8'h24, 32'h0100_0000);
		rchk(8'h2C, 32'h0100_0000);
		chk_bit(irq, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_0002);
		serve(4'h2, 12'hABC);
		serve(4'h5, 12'h123);
		n = 0;
		repeat (20) begin @(posedge pclk); n += conv_req; end
		chk(n, 0);
		chk_bit(irq, 1'b1);
		rchk(8'h58, 32'h0000_0ABC);
		rchk(8'h64, 32'h0000_0123);
		rchk(8'h20, 32'h0000_5123);
		rchk(8'h30, 32'h0300_0024);
		@(posedge pclk);
		chk_bit(irq, 1'b0);
		$display("test conversion done");
	endtask : t_conv

	task t_soft;
		apb(1'b1, 8'h00, 32'h0000_0001);
		rchk(8'h18, 32'h0);
		rchk(8'h2C, 32'h0);
		rchk(8'h58, 32'h0);
		$display("test soft reset done");
	endtask : t_soft

	task t_lock;
		apb(1'b1, 8'hE4, 32'h5A5A_5A01);
		apb(1'b1, 8'h04, 32'h8000_0000);
		rchk(8'h04, 32'h0);
		rchk(8'hE8, 32'h0000_0401);
		apb(1'b1, 8'hE4, 32'h5A5A_5A00);
		apb(1'b1, 8'h04, 32'h8000_0000);
		rchk(8'h04, 32'h8000_0000);
		$display("test lock done");
	endtask : t_lock

	// Ordered list (mode left on by the lock test), window, overrun, disarm.
	task t_order;
		apb(1'b1, 8'h08, 32'h0000_0077);
		apb(1'b1, 8'h10, 32'h0000_0003);
		apb(1'b1, 8'h40, 32'h0000_0202);
		apb(1'b1, 8'h44, 32'h0800_0100);
		apb(1'b1, 8'h24, 32'h0400_0000);
		apb(1'b1, 8'h00, 32'h0000_0002);
		serve(4'h7, 12'h400);
		serve(4'h7, 12'h900);
		repeat (5) @(posedge pclk);
		chk_bit(irq, 1'b1);
		rchk(8'h20, 32'h0000_7900);
		rchk(8'h6C, 32'h0000_0900);
		rchk(8'h3C, 32'h0000_0080);
		apb(1'b1, 8'h28, 32'h0400_0000);
		rchk(8'h2C, 32'h0);
		chk_bit(irq, 1'b0);
		rchk(8'h30, 32'h0700_0080);
		rchk(8'h3C, 32'h0);
		$display("test order done");
	endtask : t_order

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		err_total = 0; comparisons = 0;
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0; conv_done = 1'b0; conv_data = 12'h000;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_conv();
		t_soft();
		t_lock();
		t_order();
		wrap_up();
	end
endmodule : arc_regs_tb_top

/* arc_seq.sv */
// Conversion sequencer: walks the enabled slots after one start command.
// Assumes the analog cell answers each request with a done pulse.
`timescale 1ns/1ps
module arc_seq (
	// Clock and reset
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       clr,
	// Control
	input  wire logic                       start,
	input  wire logic [arc_pkg::N_CH-1:0]   active,
	input  wire logic                       use_order,
	input  wire logic [63:0]                order,
	output logic                            busy,
	// Analog cell
	output logic                            conv_req,
	output logic [arc_pkg::CH_W-1:0]        conv_chan,
	input  wire logic                       conv_done,
	input  wire logic [arc_pkg::RES_W-1:0]  conv_data,
	// Results
	output logic                            res_valid,
	output logic [arc_pkg::CH_W-1:0]        res_chan,
	output logic [arc_pkg::RES_W-1:0]       res_data
);

	arc_pkg::arc_seq_e          state;
	logic [arc_pkg::CH_W-1:0]   slot;
	logic [arc_pkg::CH_W-1:0]   slot_chan;
	logic                       issue;

	assign busy      = state != arc_pkg::SEQ_IDLE;
	assign slot_chan = use_order ? order[{slot, 2'h0} +: 4] : slot;
	assign issue     = state == arc_pkg::SEQ_SCAN && active[slot];

	// Starts that arrive while a sequence runs are ignored.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn) begin
			state <= arc_pkg::SEQ_IDLE;
			slot  <= 4'h0;
		end else if (clr) begin
			state <= arc_pkg::SEQ_IDLE;
			slot  <= 4'h0;
		end else begin
			unique case (state)
				arc_pkg::SEQ_IDLE:
				if (start) begin
					slot  <= 4'h0;
					state <= arc_pkg::SEQ_SCAN;
				end
				arc_pkg::SEQ_SCAN:
				if (active[slot])
					state <= arc_pkg::SEQ_WAIT;
				else if (slot == 4'hF)
					state <= arc_pkg::SEQ_IDLE;
				else
					slot <= slot + 4'h1;
				arc_pkg::SEQ_WAIT:
				if (conv_done) begin
					if (slot == 4'hF)
						state <= arc_pkg::SEQ_IDLE;
					else begin
						slot  <= slot + 4'h1;
						state <= arc_pkg::SEQ_SCAN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn) begin
			conv_req  <= 1'b0;
			conv_chan <= 4'h0;
		end else begin
			conv_req <= issue && !clr;
			if (issue)
				conv_chan <= slot_chan;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn) begin
			res_valid <= 1'b0;
			res_chan  <= 4'h0;
			res_data  <= '0;
		end else begin
			res_valid <= state == arc_pkg::SEQ_WAIT && conv_done && !clr;
			if (state == arc_pkg::SEQ_WAIT && conv_done) begin
				res_chan <= conv_chan;
				res_data <= conv_data;
			end
		end
	end

	// ********************************************************************
	// Assertions
	// ********************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_start_runs;
		!busy && start && !clr |=> busy ##1 state == arc_pkg::SEQ_SCAN
			|| state != arc_pkg::SEQ_IDLE;
	endproperty
	a_start_runs: assert property (p_start_runs)
		else $error("Start did not launch a sequence.");

	property p_slot_issued;
		issue && !clr |=> conv_req && state == arc_pkg::SEQ_WAIT;
	endproperty
	a_slot_issued: assert property (p_slot_issued)
		else $error("Enabled slot was not converted.");

	c_seq_done: cover property (busy ##1 !busy);

endmodule : arc_seq
